// [test_temperature_zone_supervisor.sv]
// Self-checking bench: register port, scans, range checks, warnings.
// Assumes a short tick so on/off and timers run in simulation.
`timescale 1ns/1ps
module test_temperature_zone_supervisor
    import tzs_pkg::*;
;
    logic clk_in = 0, nrst_in = 0, enable_in = 0, heat_cool_in = 0;
    logic scan_in = 0, chan_read_done_in = 0, wr_en_in = 0, rd_en_in = 0;
    logic [4:0] addr_in = 5'h00;
    logic [15:0] wr_data_in = 16'h0000, ctrl = 16'h0064, d;
    logic [31:0][15:0] temps = '0;
    logic [31:0] heat_drive_out, cool_drive_out, msk, zone;
    logic err_out, alarm_out, pid_solve_out, irq_out;
    logic [15:0] rd_data_out;
    tzs_pt_data_t pt;
    tzs_tbl_req_t req;
    int fail_count = 0, checked = 0, cycles = 0, first, count;
    int solves = 0, last_solve = 0;
    logic [4:0] ad [10] = '{5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h04, 5'h05,
                            5'h06, 5'h07, 5'h08, 5'h1f};
    logic [15:0] ex [10] = '{16'h0102, 16'h005a, 16'h0258, 16'h0100,
                             16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    tzs_supervisor #(.TICK_CYCLES(2)) i_tzs_supervisor (.clk_in(clk_in),
        .nrst_in(nrst_in), .enable_in(enable_in), .heat_cool_in(heat_cool_in),
        .scan_in(scan_in), .chan_read_done_in(chan_read_done_in),
        .pt_data_in(pt), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .tbl_req_out(req),
        .heat_drive_out(heat_drive_out), .cool_drive_out(cool_drive_out),
        .err_out(err_out), .alarm_out(alarm_out), .irq_out(irq_out),
        .pid_solve_out(pid_solve_out), .rd_data_out(rd_data_out));
    tzs_point_model i_tzs_point_model (.clk_in(clk_in), .req_in(req),
        .temp_in(temps), .ctrl_in(ctrl), .data_out(pt));
    always #2.5 clk_in = ~clk_in;
    // Hang guard, well above the planned run length; solve pulse spacing
    always @(posedge clk_in) begin
        cycles++;
        // Default 4 s interval at 100 ticks of 2 cycles each
        if (pid_solve_out) begin
            if (solves > 0)
                check("solve gap", cycles - last_solve, 32'd800);
            solves++;
            last_solve = cycles;
        end
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [15:0] v);
        @(posedge clk_in) {wr_en_in, addr_in, wr_data_in} <= {1'b1, a, v};
        @(posedge clk_in) wr_en_in <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a);
        @(posedge clk_in) {rd_en_in, addr_in} <= {1'b1, a};
        @(posedge clk_in) rd_en_in <= 1'b0;
        // Take the word mid-cycle, return on an edge for the next drive
        @(negedge clk_in) d = rd_data_out;
        @(posedge clk_in);
    endtask
    // Walk time is fixed by the hand-over: about three cycles a point
    task automatic scan();
        @(posedge clk_in) scan_in <= 1'b1;
        @(posedge clk_in) scan_in <= 1'b0;
        repeat (104) @(posedge clk_in);
    endtask
    // In-zone expectation over the counted points; band is inclusive
    function automatic logic [31:0] zone_exp(int f, int c);
        logic [31:0] z = '0;
        for (int n = 0; n < c; n++) begin
            z[n] = (temps[f+n] >= 16'd950) && (temps[f+n] <= 16'd1050);
        end
        return z;
    endfunction
    task automatic complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h2fe282c6));
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(ad[i]);
            check("reset word", d, ex[i]);
        end
        wr(TZS_OFF_HP_THR, 16'h0070);
        rd(TZS_OFF_HP_THR);
        check("thr clamp", d, 16'h0064);
        wr(TZS_OFF_HP_DUR, 16'h0010);
        rd(TZS_OFF_HP_DUR);
        check("dur clamp", d, 16'h003c);
        enable_in <= 1'b1;
        scan();
        rd(TZS_OFF_STATUS);
        check("not ready", d[0], 1'b0);
        chan_read_done_in <= 1'b1;
        heat_cool_in <= 1'b1;
        wr(TZS_OFF_IRQ_MASK, 16'h0003);
        $display("test defaults done");
        // Bad ranges: count zero, then sum of 33
        wr(TZS_OFF_RANGE, 16'h0005);
        scan();
        check("err count0", err_out, 1'b1);
        wr(TZS_OFF_RANGE, 16'h1f02);
        scan();
        check("err sum", err_out, 1'b1);
        // Clear the range error event so it cannot mask the alarm checks
        rd(TZS_OFF_IRQ_STAT);
        check("irq err", d[TZS_IRQ_ERR], 1'b1);
        for (int i = 0; i < 8; i++) begin
            first = (i == 0) ? 31 : (i == 1) ? 0 : $urandom % 32;
            count = (i == 0) ? 1 : (i == 1) ? 32 : 1 + $urandom % (32 - first);
            for (int p = 0; p < 32; p++) begin
                temps[p] = ($urandom % 2) ? 16'd1000 + ($urandom % 81) - 40
                         : 16'd1000 + (($urandom % 2) ? 16'd160 : -16'd160);
            end
            msk = (count == 32) ? 32'hffffffff : (32'h1 << count) - 1;
            zone = zone_exp(first, count);
            wr(TZS_OFF_RANGE, {8'(count), 8'(first)});
            scan();
            check("err good", err_out, 1'b0);
            rd(TZS_OFF_ZONE_LO);
            check("zone lo", d & msk[15:0], zone[15:0]);
            rd(TZS_OFF_ZONE_HI);
            check("zone hi", d & msk[31:16], zone[31:16]);
            check("alarm", alarm_out, zone != msk);
            check("irq", irq_out, zone != msk);
            rd(TZS_OFF_IRQ_STAT);
            check("irq clear", irq_out, 1'b0);
            check("heat", heat_drive_out & msk, msk);
            check("cool off", cool_drive_out, 32'h0);
        end
        $display("test zones done");
        // Every point hot: warning only on the tenth scan
        wr(TZS_OFF_RANGE, 16'h2000);
        wr(TZS_OFF_HI_LIM, 16'h0000);
        repeat (9) scan();
        rd(TZS_OFF_WARN_LO);
        check("warn early", d, 16'h0000);
        scan();
        rd(TZS_OFF_WARN_LO);
        check("warn lo", d, 16'hffff);
        rd(TZS_OFF_WARN_HI);
        check("warn hi", d, 16'hffff);
        check("alarm warn", alarm_out, 1'b1);
        heat_cool_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        check("cool", cool_drive_out, 32'hffffffff);
        check("heat off", heat_drive_out, 32'h0);
        check("solves", solves > 1, 1'b1);
        $display("test warnings done");
        complete_run();
    end
endmodule

// [tzs_pkg.sv]
// Shared constants and types of the temperature zone supervisor.
// Assumes a 200 MHz system clock and a word-addressed register port.
package tzs_pkg;
    localparam int TZS_NPTS = 32;
    localparam int TZS_CLK_HZ = 200_000_000;
    localparam int TZS_TICK_MS = 10;
    localparam int TZS_TICK_CYCLES = TZS_CLK_HZ / 1000 * TZS_TICK_MS;
    // Working area, relative word positions
    localparam logic [4:0] TZS_OFF_ZONE_LO = 5'h00;
    localparam logic [4:0] TZS_OFF_ZONE_HI = 5'h01;
    localparam logic [4:0] TZS_OFF_WARN_LO = 5'h02;
    localparam logic [4:0] TZS_OFF_WARN_HI = 5'h03;
    localparam logic [4:0] TZS_OFF_RESV_LO = 5'h04;
    localparam logic [4:0] TZS_OFF_RESV_HI = 5'h08;
    localparam logic [4:0] TZS_OFF_INTV = 5'h09;
    localparam logic [4:0] TZS_OFF_HP_THR = 5'h0a;
    localparam logic [4:0] TZS_OFF_HP_DUR = 5'h0b;
    localparam logic [4:0] TZS_OFF_HI_LIM = 5'h0c;
    localparam logic [4:0] TZS_OFF_RANGE = 5'h0d;
    localparam logic [4:0] TZS_OFF_SP_BASE = 5'h0e;
    localparam logic [4:0] TZS_OFF_DEV_BASE = 5'h0f;
    localparam logic [4:0] TZS_OFF_CTL_BASE = 5'h10;
    localparam logic [4:0] TZS_OFF_IRQ_STAT = 5'h11;
    localparam logic [4:0] TZS_OFF_IRQ_MASK = 5'h12;
    localparam logic [4:0] TZS_OFF_STATUS = 5'h13;
    // Reset values and limits
    localparam logic [15:0] TZS_INTV_RST = 16'h0102;
    localparam logic [15:0] TZS_HP_THR_MIN = 16'h0050;
    localparam logic [15:0] TZS_HP_THR_MAX = 16'h0064;
    localparam logic [15:0] TZS_HP_THR_RST = 16'h005a;
    localparam logic [15:0] TZS_HP_DUR_MIN = 16'h003c;
    localparam logic [15:0] TZS_HP_DUR_RST = 16'h0258;
    localparam logic [15:0] TZS_HI_LIM_RST = 16'h7fff;
    localparam logic [15:0] TZS_RANGE_RST = 16'h0100;
    localparam logic [7:0] TZS_FIRST_MAX = 8'h1f;
    localparam logic [7:0] TZS_COUNT_MAX = 8'h20;
    localparam logic [8:0] TZS_SUM_MAX = 9'h020;
    localparam logic [7:0] TZS_CODE_TOP = 8'h05;
    localparam logic [3:0] TZS_OT_SCANS = 4'ha;
    localparam logic [6:0] TZS_FULL_PCT = 7'h64;
    localparam logic [6:0] TZS_STEPS = 7'h64;
    // Interrupt bit positions
    localparam int TZS_IRQ_W = 3;
    localparam int TZS_IRQ_ERR = 0;
    localparam int TZS_IRQ_ALM = 1;
    localparam int TZS_IRQ_DONE = 2;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_HOLD, ST_EVAL} tzs_state_t;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] setpt;
        logic [15:0] dev;
        logic [15:0] ctrl;
    } tzs_pt_data_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  point;
        logic [15:0] sp_addr;
        logic [15:0] dev_addr;
        logic [15:0] ctl_addr;
    } tzs_tbl_req_t;
endpackage

// [tzs_point_model.sv]
// Point data source standing in for the temperature modules and tables.
// Assumes one request at a time; data is only meaningful the cycle after.
`timescale 1ns/1ps
module tzs_point_model
    import tzs_pkg::*;
(
    input  wire logic              clk_in,
    input  wire tzs_tbl_req_t      req_in,
    input  wire logic [31:0][15:0] temp_in,
    input  wire logic [15:0]       ctrl_in,
    output tzs_pt_data_t           data_out
);
    // Answer a request next cycle; else toggle so stale data never passes
    always_ff @(posedge clk_in) begin
        if (req_in.valid) begin
            data_out <= {temp_in[req_in.point], 16'h03e8, 16'h0032, ctrl_in};
        end else begin
            data_out <= ~data_out;
        end
    end
endmodule

// [tzs_supervisor.sv]
// Temperature zone supervisor: walks the controlled points once per
// program scan, keeps in-zone and warning words, drives on/off outputs.
// Assumes point data answers one cycle after each table request.
//
// Contract
// R01: Stay inactive until all temperature channels were read once; pid_solve_out still pulses on its interval before then.
// R02: While enabled, heat when select is 1, cool when it is 0.
// R03: First 0..31, count 1..32, sum at most 32; else idle and error.
// R04: Set a point's in-zone bit when temperature lies within its band.
// R05: Outside the band, clear in-zone bit and raise alarm.
// R06: Ten consecutive scans at or above high limit set warning, alarm.
// R07: High power held for the duration outside band sets warning, alarm.
// R08: Nine private working words; software must not reuse them.
// R09: In-zone words: low word points first+0..15, high first+16..31.
// R10: Warning words: third word first+n, fourth word first+16+n.
// R11: Working words 4 to 8 are internal and read as zero.
// R12: Setpoint, band and output tables start at their own bases.
// R13: Control value becomes a time-proportional on/off drive.
// R14: Interval low byte: codes 0..4 give 1..16 s, above 32 s; 4 s.
// R15: Interval high byte selects on/off period likewise; default 2 s.
// R16: High-power threshold is 80 to 100 percent, default 90.
// R17: High-power duration 60 to 65535 seconds, default 600.
// R18: Alarm is the OR of out-of-zone and warning over the scan.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module tzs_supervisor
    import tzs_pkg::*;
#(
    parameter int TICK_CYCLES = TZS_TICK_CYCLES
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic         enable_in,
    input  wire logic         heat_cool_in,
    input  wire logic         scan_in,
    input  wire logic         chan_read_done_in,
    input  wire tzs_pt_data_t pt_data_in,
    input  wire logic [4:0]   addr_in,
    input  wire logic [15:0]  wr_data_in,
    input  wire logic         wr_en_in,
    input  wire logic         rd_en_in,
    output tzs_tbl_req_t      tbl_req_out,
    output logic [31:0]       heat_drive_out,
    output logic [31:0]       cool_drive_out,
    output logic              err_out,
    output logic              alarm_out,
    output logic              pid_solve_out,
    output logic              irq_out,
    output logic [15:0]       rd_data_out
);

    // Period mask 2^code - 1, saturating at the 32 s code
    function automatic logic [4:0] tzs_code_mask(input logic [7:0] code);
        logic [4:0] m;
        m = 5'h1f;
        if (code < TZS_CODE_TOP)
            m = 5'((6'h01 << code[2:0]) - 6'h01);
        return m;
    endfunction

    // Signed distance from set point compared with an unsigned band
    function automatic logic tzs_in_band(input logic [15:0] t,
                                         input logic [15:0] sp,
                                         input logic [15:0] dv);
        logic signed [17:0] d;
        d = $signed({{2{t[15]}}, t}) - $signed({{2{sp[15]}}, sp});
        if (d < 0)
            d = -d;
        return d <= $signed({2'b00, dv});
    endfunction

    tzs_state_t   st_r;
    tzs_tbl_req_t req_r;
    logic         ready_r;
    logic         err_r;
    logic         alarm_r;
    logic         solve_r;
    logic         irq_r;
    logic [4:0]   idx_r;
    logic [31:0]  zone_r;
    logic [31:0]  warn_r;
    logic [31:0]  zone_acc_r;
    logic [31:0]  warn_acc_r;
    logic         alm_acc_r;
    logic [3:0]   ot_cnt_r [TZS_NPTS];
    logic [15:0]  hp_start_r [TZS_NPTS];
    logic [6:0]   duty_r [TZS_NPTS];
    logic [31:0]  hp_act_r;
    logic [31:0]  tick_cnt_r;
    logic [6:0]   hund_r;
    logic [15:0]  sec_now_r;
    logic [4:0]   pwm_pre_r;
    logic [6:0]   phase_r;
    logic [31:0]  heat_drv_r;
    logic [31:0]  cool_drv_r;
    logic [15:0]  rd_data_r;
    logic [15:0]  intv_r;
    logic [15:0]  hp_thr_r;
    logic [15:0]  hp_dur_r;
    logic [15:0]  hi_lim_r;
    logic [15:0]  range_r;
    logic [15:0]  sp_base_r;
    logic [15:0]  dev_base_r;
    logic [15:0]  ctl_base_r;
    logic [TZS_IRQ_W-1:0] irq_stat_r;
    logic [TZS_IRQ_W-1:0] irq_mask_r;

    // Range check and scan start
    wire logic [7:0] first_w = range_r[7:0];
    wire logic [7:0] count_w = range_r[15:8];
    wire logic [8:0] sum_w = {1'b0, first_w} + {1'b0, count_w};
    wire logic range_ok = (first_w <= TZS_FIRST_MAX) && (count_w != 8'h00)
                          && (count_w <= TZS_COUNT_MAX)
                          && (sum_w <= TZS_SUM_MAX); // see R03
    wire logic trigger = (st_r == ST_IDLE) && scan_in && enable_in
                         && ready_r; // see R01
    wire logic start = trigger && range_ok;
    wire logic bad = trigger && !range_ok; // see R03
    wire logic last = ({3'h0, idx_r} == 8'(count_w - 8'h01));
    wire logic publish = (st_r == ST_EVAL) && last;
    wire logic [4:0] pnt_w = 5'(first_w[4:0] + idx_r);

    // Per-point evaluation of the sample present in ST_EVAL
    wire logic band_ok = tzs_in_band(pt_data_in.temp, pt_data_in.setpt,
                                     pt_data_in.dev); // see R04
    wire logic hot = $signed(pt_data_in.temp) >= $signed(hi_lim_r);
    wire logic [3:0] ot_cur = ot_cnt_r[idx_r];
    wire logic ot_trip = hot && (ot_cur >= TZS_OT_SCANS - 4'h1); // see R06
    wire logic [3:0] ot_upd = !hot ? 4'h0 :
                              (ot_trip ? TZS_OT_SCANS : ot_cur + 4'h1);
    wire logic hp_cond = (pt_data_in.ctrl >= hp_thr_r) && !band_ok;
    wire logic [15:0] hp_age = sec_now_r - hp_start_r[idx_r];
    wire logic hp_trip = hp_cond && hp_act_r[idx_r]
                         && (hp_age >= hp_dur_r); // see R07
    wire logic warn_pt = ot_trip || hp_trip; // see R10
    wire logic alm_pt = !band_ok || warn_pt; // see R05
    wire logic [31:0] pt_bit = 32'h1 << idx_r; // see R09
    wire logic [31:0] zone_acc_nxt = band_ok ? (zone_acc_r | pt_bit)
                                             : (zone_acc_r & ~pt_bit);
    wire logic [31:0] warn_acc_nxt = warn_pt ? (warn_acc_r | pt_bit)
                                             : warn_acc_r;
    wire logic alm_acc_nxt = alm_acc_r || alm_pt; // see R18
    wire logic [6:0] duty_upd = (pt_data_in.ctrl >= 16'(TZS_FULL_PCT)) ?
                                TZS_FULL_PCT : pt_data_in.ctrl[6:0];

    // Walk of the point range, three cycles per point
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= ST_IDLE;
            idx_r <= 5'h00;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    idx_r <= 5'h00;
                    if (start)
                        st_r <= ST_LOAD;
                end
                ST_LOAD: st_r <= ST_HOLD;
                ST_HOLD: st_r <= ST_EVAL;
                ST_EVAL: begin
                    idx_r <= idx_r + 5'h01;
                    st_r <= last ? ST_IDLE : ST_LOAD;
                end
            endcase
        end
    end

    // Table request: entry n sits at base + point index
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_r <= '0;
        end else begin
            req_r.valid <= (st_r == ST_LOAD);
            req_r.point <= pnt_w;
            req_r.sp_addr <= sp_base_r + {11'h000, pnt_w}; // see R12
            req_r.dev_addr <= dev_base_r + {11'h000, pnt_w};
            req_r.ctl_addr <= ctl_base_r + {11'h000, pnt_w};
        end
    end

    // Scan accumulators, published whole so reads never see half a scan
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            zone_acc_r <= 32'h0;
            warn_acc_r <= 32'h0;
            alm_acc_r <= 1'b0;
            zone_r <= 32'h0;
            warn_r <= 32'h0;
            alarm_r <= 1'b0;
            err_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            ready_r <= ready_r || chan_read_done_in; // see R01
            if (bad)
                err_r <= 1'b1;
            else if (start)
                err_r <= 1'b0;
            if (start) begin
                zone_acc_r <= 32'h0;
                warn_acc_r <= 32'h0;
                alm_acc_r <= 1'b0;
            end else if (st_r == ST_EVAL) begin
                zone_acc_r <= zone_acc_nxt;
                warn_acc_r <= warn_acc_nxt;
                alm_acc_r <= alm_acc_nxt;
            end
            if (publish) begin
                zone_r <= zone_acc_nxt; // see R09
                warn_r <= warn_acc_nxt; // see R10
                alarm_r <= alm_acc_nxt; // see R18
            end
        end
    end

    // Per-point history: over-temperature run, high-power start, duty
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hp_act_r <= 32'h0;
            for (int i = 0; i < TZS_NPTS; i++) begin
                ot_cnt_r[i] <= 4'h0;
                hp_start_r[i] <= 16'h0000;
                duty_r[i] <= 7'h00;
            end
        end else if (st_r == ST_EVAL) begin
            ot_cnt_r[idx_r] <= ot_upd; // see R06
            hp_act_r[idx_r] <= hp_cond; // see R07
            if (hp_cond && !hp_act_r[idx_r])
                hp_start_r[idx_r] <= sec_now_r;
            duty_r[idx_r] <= duty_upd; // see R13
        end
    end

    // Time base: 10 ms ticks, seconds, on/off phase in hundredths
    wire logic tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    wire logic sec_tick = tick && (hund_r == TZS_STEPS - 7'h01);
    wire logic [4:0] solve_mask = tzs_code_mask(intv_r[7:0]); // see R14
    wire logic [4:0] pwm_mask = tzs_code_mask(intv_r[15:8]); // see R15
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_cnt_r <= 32'h0;
            hund_r <= 7'h00;
            sec_now_r <= 16'h0000;
            solve_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            if (tick)
                hund_r <= sec_tick ? 7'h00 : hund_r + 7'h01;
            if (sec_tick)
                sec_now_r <= sec_now_r + 16'h0001;
            solve_r <= sec_tick
                       && ((sec_now_r[4:0] & solve_mask) == solve_mask);
        end
    end

    // Period is 100 steps of 2^code ticks, i.e. 2^code seconds
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwm_pre_r <= 5'h00;
            phase_r <= 7'h00;
        end else if (tick) begin
            if (pwm_pre_r >= pwm_mask) begin // see R15
                pwm_pre_r <= 5'h00;
                phase_r <= (phase_r == TZS_STEPS - 7'h01) ? 7'h00
                                                          : phase_r + 7'h01;
            end else begin
                pwm_pre_r <= pwm_pre_r + 5'h01;
            end
        end
    end

    // Drive is on while the phase is below the point's duty
    logic [31:0] drv_w;
    always_comb begin
        for (int i = 0; i < TZS_NPTS; i++)
            drv_w[i] = enable_in && (duty_r[i] > phase_r); // see R13
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            heat_drv_r <= 32'h0;
            cool_drv_r <= 32'h0;
        end else begin
            heat_drv_r <= heat_cool_in ? drv_w : 32'h0; // see R02
            cool_drv_r <= heat_cool_in ? 32'h0 : drv_w; // see R02
        end
    end

    // Register writes; threshold and duration are clamped so logic never sees bad values
    wire logic wr_thr = wr_en_in && (addr_in == TZS_OFF_HP_THR);
    wire logic wr_dur = wr_en_in && (addr_in == TZS_OFF_HP_DUR);
    wire logic [15:0] thr_clamp =
        (wr_data_in < TZS_HP_THR_MIN) ? TZS_HP_THR_MIN :
        (wr_data_in > TZS_HP_THR_MAX) ? TZS_HP_THR_MAX : wr_data_in;
    wire logic [15:0] dur_clamp =
        (wr_data_in < TZS_HP_DUR_MIN) ? TZS_HP_DUR_MIN : wr_data_in;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            intv_r <= TZS_INTV_RST;
            hp_thr_r <= TZS_HP_THR_RST;
            hp_dur_r <= TZS_HP_DUR_RST;
            hi_lim_r <= TZS_HI_LIM_RST;
            range_r <= TZS_RANGE_RST;
            sp_base_r <= 16'h0000;
            dev_base_r <= 16'h0000;
            ctl_base_r <= 16'h0000;
            irq_mask_r <= '0;
        end else if (wr_en_in) begin
            if (addr_in == TZS_OFF_INTV)
                intv_r <= wr_data_in; // see R14
            if (wr_thr)
                hp_thr_r <= thr_clamp; // see R16
            if (wr_dur)
                hp_dur_r <= dur_clamp; // see R17
            if (addr_in == TZS_OFF_HI_LIM)
                hi_lim_r <= wr_data_in;
            if (addr_in == TZS_OFF_RANGE)
                range_r <= wr_data_in;
            if (addr_in == TZS_OFF_SP_BASE)
                sp_base_r <= wr_data_in;
            if (addr_in == TZS_OFF_DEV_BASE)
                dev_base_r <= wr_data_in;
            if (addr_in == TZS_OFF_CTL_BASE)
                ctl_base_r <= wr_data_in;
            if (addr_in == TZS_OFF_IRQ_MASK)
                irq_mask_r <= wr_data_in[TZS_IRQ_W-1:0];
        end
    end

    // Read decode; the nine working words come first
    wire logic [15:0] zone_hi_w = zone_r[31:16];
    wire logic [15:0] warn_hi_w = warn_r[31:16];
    wire logic resv = (addr_in >= TZS_OFF_RESV_LO)
                      && (addr_in <= TZS_OFF_RESV_HI); // see R08
    wire logic [15:0] stat_w = {12'h000, st_r != ST_IDLE, alarm_r,
                                err_r, ready_r};
    wire logic [15:0] rd_mux =
        resv ? 16'h0000 : // see R11
        (addr_in == TZS_OFF_ZONE_LO) ? zone_r[15:0] :
        (addr_in == TZS_OFF_ZONE_HI) ? zone_hi_w :
        (addr_in == TZS_OFF_WARN_LO) ? warn_r[15:0] :
        (addr_in == TZS_OFF_WARN_HI) ? warn_hi_w :
        (addr_in == TZS_OFF_INTV) ? intv_r :
        (addr_in == TZS_OFF_HP_THR) ? hp_thr_r :
        (addr_in == TZS_OFF_HP_DUR) ? hp_dur_r :
        (addr_in == TZS_OFF_HI_LIM) ? hi_lim_r :
        (addr_in == TZS_OFF_RANGE) ? range_r :
        (addr_in == TZS_OFF_SP_BASE) ? sp_base_r :
        (addr_in == TZS_OFF_DEV_BASE) ? dev_base_r :
        (addr_in == TZS_OFF_CTL_BASE) ? ctl_base_r :
        (addr_in == TZS_OFF_IRQ_STAT) ? 16'(irq_stat_r) :
        (addr_in == TZS_OFF_IRQ_MASK) ? 16'(irq_mask_r) :
        (addr_in == TZS_OFF_STATUS) ? stat_w : 16'h0000;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            rd_data_r <= 16'h0000;
        else
            rd_data_r <= rd_en_in ? rd_mux : 16'h0000;
    end

    // Sticky events; a new event wins over the clearing read
    wire logic stat_rd = rd_en_in && (addr_in == TZS_OFF_IRQ_STAT);
    wire logic [TZS_IRQ_W-1:0] irq_ev = {publish, publish && alm_acc_nxt,
                                         bad};
    wire logic [TZS_IRQ_W-1:0] irq_nxt =
        (stat_rd ? '0 : irq_stat_r) | irq_ev;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_nxt;
            irq_r <= |(irq_nxt & irq_mask_r);
        end
    end

    assign tbl_req_out = req_r;
    assign heat_drive_out = heat_drv_r;
    assign cool_drive_out = cool_drv_r;
    assign err_out = err_r;
    assign alarm_out = alarm_r;
    assign pid_solve_out = solve_r;
    assign irq_out = irq_r;
    assign rd_data_out = rd_data_r;

    default clocking tzs_cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_unready_idle: assert property ( // see R01
        st_r == ST_IDLE && !ready_r |=> st_r == ST_IDLE)
        else $error("walk started before channels were read");
    a_cool_blank: assert property ( // see R02
        $past(heat_cool_in) |-> cool_drive_out == 32'h0)
        else $error("cooling drive active in heating mode");
    a_range_error: assert property ( // see R03
        bad |=> err_out && st_r == ST_IDLE)
        else $error("bad point range not flagged");
    a_zone_set: assert property ( // see R04
        st_r == ST_EVAL && band_ok |=> zone_acc_r[$past(idx_r)])
        else $error("in-zone bit not set");
    a_out_alarm: assert property ( // see R05
        st_r == ST_EVAL && !band_ok |=> alm_acc_r
        && !zone_acc_r[$past(idx_r)])
        else $error("out-of-zone point did not alarm");
    a_ot_early: assert property ( // see R06
        st_r == ST_EVAL && hot && ot_cur < 4'h9 && !hp_trip
        |=> !warn_acc_r[$past(idx_r)])
        else $error("over-temperature warning too early");
    a_ot_warn: assert property ( // see R06
        st_r == ST_EVAL && ot_trip |=> warn_acc_r[$past(idx_r)])
        else $error("over-temperature warning missed");
    a_hp_warn: assert property ( // see R07
        st_r == ST_EVAL && hp_trip |=> warn_acc_r[$past(idx_r)])
        else $error("open heater warning missed");
    a_word_map: assert property ( // see R09
        rd_en_in && addr_in == TZS_OFF_ZONE_HI
        |=> rd_data_out == $past(zone_hi_w))
        else $error("high in-zone word mismatch");
    a_warn_word: assert property ( // see R10
        rd_en_in && addr_in == TZS_OFF_WARN_HI
        |=> rd_data_out == $past(warn_hi_w))
        else $error("high warning word mismatch");
    a_resv_zero: assert property ( // see R11
        rd_en_in && resv |=> rd_data_out == 16'h0000)
        else $error("internal word exposed");
    a_tbl_addr: assert property ( // see R12
        tbl_req_out.valid |=> ##0
        $past(tbl_req_out.dev_addr) == dev_base_r
        + {11'h000, $past(tbl_req_out.point)} || $past(wr_en_in))
        else $error("band table address wrong");
    a_drive_duty: assert property ( // see R13
        enable_in && heat_cool_in && duty_r[0] > phase_r
        |=> heat_drive_out[0])
        else $error("drive off while below duty");
    a_thr_clamp: assert property ( // see R16
        hp_thr_r >= TZS_HP_THR_MIN && hp_thr_r <= TZS_HP_THR_MAX)
        else $error("threshold out of range");
    a_dur_floor: assert property ( // see R17
        hp_dur_r >= TZS_HP_DUR_MIN)
        else $error("duration below floor");
    a_alarm_pub: assert property ( // see R18
        publish |=> alarm_out == $past(alm_acc_nxt))
        else $error("alarm not published");
endmodule
